// ### common/ustx_params.svh
`ifndef USTX_PARAMS_SVH
`define USTX_PARAMS_SVH

// ==========================================================================
// Register addresses on the special function register port
`define USTX_ADDR_TIMER2_CONTROL 11'h418
`define USTX_ADDR_SYSTEM_CONFIG 11'h440
`define USTX_ADDR_SERIAL_CONTROL_STATUS 11'h420
`define USTX_ADDR_SERIAL_BUFFER 11'h421
`define USTX_ADDR_SERIAL_EXT_STATUS 11'h422
`define USTX_ADDR_T1_RELOAD_LO 11'h430
`define USTX_ADDR_T1_RELOAD_HI 11'h431
`define USTX_ADDR_T2_RELOAD_LO 11'h432
`define USTX_ADDR_T2_RELOAD_HI 11'h433
`define USTX_ADDR_T1_CONFIG 11'h434

// ==========================================================================
// Field positions
`define USTX_BIT_RX_FLAG 0
`define USTX_BIT_TX_FLAG 1
`define USTX_BIT_RX_NINTH 2
`define USTX_BIT_TX_NINTH 3
`define USTX_BIT_RX_ENABLE 4
`define USTX_BIT_MULTIPROC 5
`define USTX_BIT_MODE_LO 6
`define USTX_BIT_MODE_HI 7
`define USTX_BIT_FRAMING_ERR 3
`define USTX_BIT_TX_SRC_T2 4
`define USTX_BIT_RX_SRC_T2 5
`define USTX_BIT_PRESCALE_LO 2
`define USTX_BIT_PRESCALE_HI 3
`define USTX_BIT_T1_WIDE 0

// ==========================================================================
// Reset values
`define USTX_RST_BYTE 8'h00

// ==========================================================================
// Timing counts
`define USTX_PRESCALE_4_LAST 6'h03
`define USTX_PRESCALE_16_LAST 6'h0F
`define USTX_PRESCALE_64_LAST 6'h3F
`define USTX_TICK_LAST 4'hF
`define USTX_TICK_MID 4'h7
`define USTX_TICK_HALF 4'h8
`define USTX_LAST_BIT_M0 4'h7
`define USTX_LAST_BIT_M1 4'h9
`define USTX_LAST_BIT_M23 4'hA
`define USTX_T1_TOP8 8'hFF
`define USTX_TIMER_TOP16 16'hFFFF

// ==========================================================================
// Interrupt arbitration ranks of the two vectors
`define USTX_RX_ARB_RANK 4'hA
`define USTX_TX_ARB_RANK 4'hB

`endif

// ### common/ustx_pkg.sv
package ustx_pkg;

  typedef enum logic {TX_IDLE, TX_SHIFT} ustx_tx_state_t;
  typedef enum logic {RX_IDLE, RX_BUSY} ustx_rx_state_t;

  typedef struct packed {
    logic [1:0] mode;
    logic mpen;
    logic ren;
    logic tx_ninth;
    logic rx_ninth;
    logic tx_flag;
    logic rx_flag;
    logic fe_flag;
    logic [7:0] t2ctl;
    logic [7:0] syscfg;
    logic t1_wide;
    logic [15:0] t1_reload;
    logic [15:0] t2_reload;
    logic [15:0] t1_cnt;
    logic [15:0] t2_cnt;
    logic [5:0] pre_cnt;
    logic half;
    ustx_tx_state_t tx_st;
    logic [7:0] tx_data;
    logic [7:0] tx_hold;
    logic tx_hold_v;
    logic [3:0] tx_bit;
    logic [3:0] tx_tick;
    ustx_rx_state_t rx_st;
    logic [10:0] rx_sh;
    logic [3:0] rx_bit;
    logic [3:0] rx_tick;
    logic [7:0] rx_buf;
    logic rxd_m;
    logic rxd_s;
    logic rxd_d;
    logic trig_m;
    logic trig_s;
    logic trig_d;
    logic [7:0] rdata;
    logic rxd_o;
    logic rxd_e;
    logic txd_o;
    logic int2;
  } ustx_state_t;

endpackage : ustx_pkg

// ### rtl/ustx_fifo.sv
module ustx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ustx_fifo_state_t;

  ustx_fifo_state_t s_r;
  ustx_fifo_state_t s_nxt;
  logic push;
  logic pop;

  assign in_ready = s_r.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_r.cnt != '0;
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : ustx_fifo

// ### rtl/ustx_serial_port.sv
`include "ustx_params.svh"

module ustx_serial_port (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Special function register port
  input wire logic [10:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Serial pins
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  input wire logic timer2_trigger_pin,
  // Interrupt requests
  output logic tx_irq,
  output logic rx_irq,
  output logic ext_int2_req
);
  ustx_pkg::ustx_state_t s_r;
  ustx_pkg::ustx_state_t s_nxt;

  logic wr_ctl;
  logic wr_buf;
  logic pre_ok;
  logic pre_tick;
  logic [5:0] pre_last;
  logic t1_ovf;
  logic t2_ovf;
  logic tx_tick_en;
  logic rx_tick_en;
  logic tx_end;
  logic set_ti;
  logic set_ri;
  logic tx_level;
  logic rx_sample;
  logic rx_finish;
  logic stop_ok;
  logic accept;
  logic push;
  logic push_ninth;
  logic [7:0] push_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [8:0] fifo_out_data;
  logic [3:0] sample_at;

  // ========================================================================
  // Frame decoding helpers
  function automatic logic [3:0] last_bit_idx(input logic [1:0] mode);
    if (mode == 2'h0) begin
      return `USTX_LAST_BIT_M0;
    end else if (mode == 2'h1) begin
      return `USTX_LAST_BIT_M1;
    end
    return `USTX_LAST_BIT_M23;
  endfunction : last_bit_idx

  function automatic logic tx_bit_val(input logic [1:0] mode,
                                      input logic [3:0] idx,
                                      input logic [7:0] data,
                                      input logic ninth);
    if (mode == 2'h0) begin
      return data[idx[2:0]];
    end else if (idx == 4'h0) begin
      return 1'b0;
    end else if (idx <= 4'h8) begin
      return data[3'(idx - 4'h1)];
    end else if (idx == 4'h9 && mode != 2'h1) begin
      return ninth;
    end
    return 1'b1;
  endfunction : tx_bit_val

  function automatic logic tick_for(input logic [1:0] mode,
                                    input logic use_t2,
                                    input logic half,
                                    input logic ovf1,
                                    input logic ovf2);
    if (mode == 2'h0) begin
      return 1'b1;
    end else if (mode == 2'h2) begin
      return half;
    end
    return use_t2 ? ovf2 : ovf1;
  endfunction : tick_for

  // ========================================================================
  // Receive FIFO
  ustx_fifo #(
    .WIDTH(9),
    .DEPTH(8)
  ) u_rx_fifo (
    .clock(clock),
    .resetn(resetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({push_ninth, push_data}),
    .out_valid(fifo_out_valid),
    .out_ready(!s_r.rx_flag),
    .out_data(fifo_out_data)
  );

  // ========================================================================
  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    wr_ctl = sfr_wr && sfr_addr == `USTX_ADDR_SERIAL_CONTROL_STATUS;
    wr_buf = sfr_wr && sfr_addr == `USTX_ADDR_SERIAL_BUFFER;
    set_ti = 1'b0;
    set_ri = 1'b0;
    push = 1'b0;
    rx_finish = 1'b0;
    rx_sample = s_r.rxd_s;

    s_nxt.rxd_m = rxd_in;
    s_nxt.rxd_s = s_r.rxd_m;
    s_nxt.rxd_d = s_r.rxd_s;
    s_nxt.trig_m = timer2_trigger_pin;
    s_nxt.trig_s = s_r.trig_m;
    s_nxt.trig_d = s_r.trig_s;
    s_nxt.half = !s_r.half;

    // Timer clock prescaler
    pre_ok = 1'b1;
    unique case (s_r.syscfg[`USTX_BIT_PRESCALE_HI:`USTX_BIT_PRESCALE_LO])
      2'h0: pre_last = `USTX_PRESCALE_4_LAST;
      2'h1: pre_last = `USTX_PRESCALE_16_LAST;
      2'h2: pre_last = `USTX_PRESCALE_64_LAST;
      2'h3: begin
        pre_last = `USTX_PRESCALE_64_LAST;
        pre_ok = 1'b0;
      end
    endcase
    pre_tick = pre_ok && s_r.pre_cnt >= pre_last;
    s_nxt.pre_cnt = (pre_tick || !pre_ok) ? 6'h00 : s_r.pre_cnt + 6'h01;

    // Baud timers: count from reload to top of range
    t1_ovf = pre_tick && (s_r.t1_wide ? s_r.t1_cnt == `USTX_TIMER_TOP16
                                      : s_r.t1_cnt[7:0] == `USTX_T1_TOP8);
    t2_ovf = pre_tick && s_r.t2_cnt == `USTX_TIMER_TOP16;
    if (pre_tick) begin
      if (t1_ovf) begin
        s_nxt.t1_cnt = s_r.t1_wide ? s_r.t1_reload
                                   : {8'h00, s_r.t1_reload[7:0]};
      end else begin
        s_nxt.t1_cnt = s_r.t1_cnt + 16'h0001;
      end
      s_nxt.t2_cnt = t2_ovf ? s_r.t2_reload : s_r.t2_cnt + 16'h0001;
    end
    tx_tick_en = tick_for(s_r.mode, s_r.t2ctl[`USTX_BIT_TX_SRC_T2],
                          s_r.half, t1_ovf, t2_ovf);
    rx_tick_en = tick_for(s_r.mode, s_r.t2ctl[`USTX_BIT_RX_SRC_T2],
                          s_r.half, t1_ovf, t2_ovf);

    // Transmitter
    tx_end = s_r.tx_st == ustx_pkg::TX_SHIFT && tx_tick_en &&
             s_r.tx_tick == `USTX_TICK_LAST &&
             s_r.tx_bit == last_bit_idx(s_r.mode);
    unique case (s_r.tx_st)
      ustx_pkg::TX_IDLE: begin
        if (wr_buf) begin
          s_nxt.tx_data = sfr_wdata;
          s_nxt.tx_st = ustx_pkg::TX_SHIFT;
          s_nxt.tx_bit = 4'h0;
          s_nxt.tx_tick = 4'h0;
          set_ti = 1'b1;
        end
      end
      ustx_pkg::TX_SHIFT: begin
        if (tx_tick_en) begin
          s_nxt.tx_tick = s_r.tx_tick + 4'h1;
          if (s_r.tx_tick == `USTX_TICK_LAST) begin
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
          end
        end
        if (tx_end) begin
          set_ti = 1'b1;
          s_nxt.tx_bit = 4'h0;
          if (s_r.tx_hold_v) begin
            s_nxt.tx_data = s_r.tx_hold;
            s_nxt.tx_hold_v = 1'b0;
          end else begin
            s_nxt.tx_st = ustx_pkg::TX_IDLE;
          end
        end
        if (wr_buf) begin
          s_nxt.tx_hold = sfr_wdata;
          s_nxt.tx_hold_v = 1'b1;
        end
      end
    endcase
    tx_level = tx_bit_val(s_r.mode, s_r.tx_bit, s_r.tx_data,
                          s_r.tx_ninth);

    // Receiver
    sample_at = (s_r.mode == 2'h0) ? `USTX_TICK_LAST : `USTX_TICK_MID;
    unique case (s_r.rx_st)
      ustx_pkg::RX_IDLE: begin
        if (s_r.mode == 2'h0) begin
          if (s_r.ren && !s_r.rx_flag && !fifo_out_valid && !wr_buf &&
              s_r.tx_st == ustx_pkg::TX_IDLE) begin
            s_nxt.rx_st = ustx_pkg::RX_BUSY;
          end
        end else if (s_r.ren && s_r.rxd_d && !s_r.rxd_s &&
                     fifo_in_ready) begin
          s_nxt.rx_st = ustx_pkg::RX_BUSY;
        end
        s_nxt.rx_bit = 4'h0;
        s_nxt.rx_tick = 4'h0;
      end
      ustx_pkg::RX_BUSY: begin
        if (rx_tick_en) begin
          s_nxt.rx_tick = s_r.rx_tick + 4'h1;
          if (s_r.rx_tick == sample_at) begin
            if (s_r.mode != 2'h0 && s_r.rx_bit == 4'h0 && rx_sample) begin
              s_nxt.rx_st = ustx_pkg::RX_IDLE;
            end else if (s_r.rx_bit == last_bit_idx(s_r.mode)) begin
              rx_finish = 1'b1;
              s_nxt.rx_st = ustx_pkg::RX_IDLE;
            end else begin
              s_nxt.rx_sh[s_r.rx_bit] = rx_sample;
            end
          end
          if (s_r.rx_tick == `USTX_TICK_LAST && !rx_finish) begin
            s_nxt.rx_bit = s_r.rx_bit + 4'h1;
          end
        end
      end
    endcase
    stop_ok = rx_sample;
    push_data = (s_r.mode == 2'h0) ? {rx_sample, s_r.rx_sh[6:0]}
                                   : s_r.rx_sh[8:1];
    if (s_r.mode == 2'h1) begin
      push_ninth = stop_ok;
      accept = !s_r.mpen || stop_ok;
    end else if (s_r.mode == 2'h0) begin
      push_ninth = s_r.rx_ninth;
      accept = 1'b1;
    end else begin
      push_ninth = s_r.rx_sh[9];
      accept = !s_r.mpen || s_r.rx_sh[9];
    end
    push = rx_finish && accept;

    // Software writes: flags can only be cleared
    if (wr_ctl) begin
      s_nxt.mode = sfr_wdata[`USTX_BIT_MODE_HI:`USTX_BIT_MODE_LO];
      s_nxt.mpen = sfr_wdata[`USTX_BIT_MULTIPROC];
      s_nxt.ren = sfr_wdata[`USTX_BIT_RX_ENABLE];
      s_nxt.tx_ninth = sfr_wdata[`USTX_BIT_TX_NINTH];
      s_nxt.rx_ninth = sfr_wdata[`USTX_BIT_RX_NINTH];
      s_nxt.tx_flag = s_r.tx_flag & sfr_wdata[`USTX_BIT_TX_FLAG];
      s_nxt.rx_flag = s_r.rx_flag & sfr_wdata[`USTX_BIT_RX_FLAG];
    end
    if (sfr_wr && sfr_addr == `USTX_ADDR_SERIAL_EXT_STATUS) begin
      s_nxt.fe_flag = s_r.fe_flag & sfr_wdata[`USTX_BIT_FRAMING_ERR];
    end
    if (sfr_wr) begin
      unique case (sfr_addr)
        `USTX_ADDR_TIMER2_CONTROL: s_nxt.t2ctl = sfr_wdata;
        `USTX_ADDR_SYSTEM_CONFIG: s_nxt.syscfg = sfr_wdata;
        `USTX_ADDR_T1_RELOAD_LO: s_nxt.t1_reload[7:0] = sfr_wdata;
        `USTX_ADDR_T1_RELOAD_HI: s_nxt.t1_reload[15:8] = sfr_wdata;
        `USTX_ADDR_T2_RELOAD_LO: s_nxt.t2_reload[7:0] = sfr_wdata;
        `USTX_ADDR_T2_RELOAD_HI: s_nxt.t2_reload[15:8] = sfr_wdata;
        `USTX_ADDR_T1_CONFIG: s_nxt.t1_wide = sfr_wdata[`USTX_BIT_T1_WIDE];
        default: ;
      endcase
    end

    // Hardware sets win over a clearing write in the same cycle
    if (set_ti) begin
      s_nxt.tx_flag = 1'b1;
    end
    if (rx_finish && s_r.mode != 2'h0 && !stop_ok) begin
      s_nxt.fe_flag = 1'b1;
    end
    if (fifo_out_valid && !s_r.rx_flag) begin
      s_nxt.rx_buf = fifo_out_data[7:0];
      s_nxt.rx_ninth = fifo_out_data[8];
      set_ri = 1'b1;
      s_nxt.rx_flag = 1'b1;
    end

    // Register reads
    if (sfr_rd) begin
      unique case (sfr_addr)
        `USTX_ADDR_SERIAL_CONTROL_STATUS:
          s_nxt.rdata = {s_r.mode, s_r.mpen, s_r.ren, s_r.tx_ninth,
                         s_r.rx_ninth, s_r.tx_flag, s_r.rx_flag};
        `USTX_ADDR_SERIAL_BUFFER: s_nxt.rdata = s_r.rx_buf;
        `USTX_ADDR_SERIAL_EXT_STATUS:
          s_nxt.rdata = {4'h0, s_r.fe_flag, 3'h0};
        `USTX_ADDR_TIMER2_CONTROL: s_nxt.rdata = s_r.t2ctl;
        `USTX_ADDR_SYSTEM_CONFIG: s_nxt.rdata = s_r.syscfg;
        `USTX_ADDR_T1_RELOAD_LO: s_nxt.rdata = s_r.t1_reload[7:0];
        `USTX_ADDR_T1_RELOAD_HI: s_nxt.rdata = s_r.t1_reload[15:8];
        `USTX_ADDR_T2_RELOAD_LO: s_nxt.rdata = s_r.t2_reload[7:0];
        `USTX_ADDR_T2_RELOAD_HI: s_nxt.rdata = s_r.t2_reload[15:8];
        `USTX_ADDR_T1_CONFIG: s_nxt.rdata = {7'h00, s_r.t1_wide};
        default: s_nxt.rdata = 8'h00;
      endcase
    end

    // Pins: mode 0 shares the receive line and clocks on the transmit line
    s_nxt.rxd_o = 1'b1;
    s_nxt.rxd_e = 1'b0;
    s_nxt.txd_o = 1'b1;
    if (s_nxt.mode == 2'h0) begin
      if (s_nxt.tx_st == ustx_pkg::TX_SHIFT) begin
        s_nxt.rxd_e = 1'b1;
        s_nxt.rxd_o = tx_bit_val(2'h0, s_nxt.tx_bit, s_nxt.tx_data, 1'b0);
        s_nxt.txd_o = s_nxt.tx_tick >= `USTX_TICK_HALF;
      end else if (s_nxt.rx_st == ustx_pkg::RX_BUSY) begin
        s_nxt.txd_o = s_nxt.rx_tick >= `USTX_TICK_HALF;
      end
    end else if (s_nxt.tx_st == ustx_pkg::TX_SHIFT) begin
      s_nxt.txd_o = tx_bit_val(s_nxt.mode, s_nxt.tx_bit, s_nxt.tx_data,
                               s_nxt.tx_ninth);
    end

    // Trigger pin turns into an interrupt input while timer 2 clocks
    s_nxt.int2 = (s_r.t2ctl[`USTX_BIT_TX_SRC_T2] ||
                  s_r.t2ctl[`USTX_BIT_RX_SRC_T2]) &&
                 s_r.trig_d && !s_r.trig_s;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sfr_rdata = s_r.rdata;
  assign rxd_out = s_r.rxd_o;
  assign rxd_oe = s_r.rxd_e;
  assign txd_out = s_r.txd_o;
  assign tx_irq = s_r.tx_flag;
  assign rx_irq = s_r.rx_flag;
  assign ext_int2_req = s_r.int2;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_idle_write_flag: assert property (
    wr_buf && s_r.tx_st == ustx_pkg::TX_IDLE |=> s_r.tx_flag &&
    s_r.tx_st == ustx_pkg::TX_SHIFT)
    else $error("idle buffer write did not set transmit flag");
  a_byte_end_flag: assert property (
    tx_end |=> s_r.tx_flag)
    else $error("transmit flag not set at byte end");
  a_no_gap_chain: assert property (
    tx_end && s_r.tx_hold_v && !wr_buf |=>
    s_r.tx_st == ustx_pkg::TX_SHIFT && s_r.tx_bit == 4'h0 && !s_r.tx_hold_v)
    else $error("held byte did not follow without gap");
  a_mode0_rate: assert property (
    s_r.mode == 2'h0 && !wr_ctl && s_r.tx_st == ustx_pkg::TX_SHIFT &&
    s_r.tx_tick != `USTX_TICK_LAST |=> s_r.tx_tick == $past(s_r.tx_tick) + 4'h1)
    else $error("mode 0 tick not every clock");
  a_mode2_rate: assert property (
    s_r.mode == 2'h2 && $stable(s_r.mode) &&
    s_r.tx_st == ustx_pkg::TX_SHIFT && $changed(s_r.tx_tick) && !tx_end
    |=> $stable(s_r.tx_tick))
    else $error("mode 2 tick faster than every other clock");
  a_mp_filter: assert property (
    push && s_r.mpen && s_r.mode[1] |-> push_ninth)
    else $error("address filter passed a data byte");
  a_mode1_stop: assert property (
    push && s_r.mpen && s_r.mode == 2'h1 |-> stop_ok)
    else $error("mode 1 byte with bad stop flagged");
  a_framing_err: assert property (
    rx_finish && s_r.mode != 2'h0 && !stop_ok |=> s_r.fe_flag)
    else $error("framing error not reported");
  a_flag_sticky: assert property (
    s_r.rx_flag && !wr_ctl |=> s_r.rx_flag)
    else $error("receive flag dropped without a write");
  a_int2_gate: assert property (
    s_r.int2 |-> $past(s_r.t2ctl[`USTX_BIT_TX_SRC_T2] ||
                       s_r.t2ctl[`USTX_BIT_RX_SRC_T2]))
    else $error("trigger interrupt while timer 2 not baud source");

  c_back_to_back: cover property (tx_end && s_r.tx_hold_v);
  c_mp_accept: cover property (push && s_r.mpen && s_r.mode[1]);
  c_framing: cover property (rx_finish && !stop_ok && s_r.mode != 2'h0);
  c_mode0_rx: cover property (rx_finish && s_r.mode == 2'h0);

endmodule : ustx_serial_port

// ### sim/ustx_peer.sv
module ustx_peer (
  // Clock
  input wire logic clock,
  // Serial lines
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int period = 32;
  int nbits = 11;
  int cyc = 0;
  logic armed = 1'b0;
  logic [10:0] got_q[$];
  int start_q[$];
  initial rxd = 1'b1;
  always @(posedge clock) cyc <= cyc + 1;
  // ==========================================================
  // Frame capture, mid-bit sampling
  always begin : grab
    logic [10:0] f;
    wait (armed);
    @(negedge txd);
    start_q.push_back(cyc);
    f = 11'h7FF;
    repeat (period / 2) @(posedge clock);
    for (int i = 0; i < nbits; i++) begin
      f[i] = txd;
      if (i < nbits - 1) repeat (period) @(posedge clock);
    end
    got_q.push_back(f);
  end
  // ==========================================================
  // Frame send, line idles high after it
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < nbits; i++) begin
      rxd <= f[i];
      repeat (period) @(posedge clock);
    end
    rxd <= 1'b1;
    @(posedge clock);
  endtask : send
  // ==========================================================
  // Mode 0 partner: next bit after each falling shift clock edge
  task automatic shift_in(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      rxd <= d[i];
    end
    @(posedge txd);
    repeat (9) @(posedge clock);
    rxd <= 1'b1;
  endtask : shift_in
endmodule : ustx_peer

// ### sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, resetn, sfr_wr, sfr_rd, trig, seen;
  logic [10:0] sfr_addr;
  logic [7:0] sfr_wdata, sfr_rdata, rd_v;
  logic rxd_out, rxd_oe, txd_out, tx_irq, rx_irq, int2, peer_rxd;
  wire logic rxd_line = rxd_oe ? rxd_out : peer_rxd;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int t_first = 0, t_last = 0;
  int seed = 1740;
  logic [7:0] b[4];
  logic [7:0] rq[$];
  ustx_serial_port ustx_serial_port_i (
    .clock(clock), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd_out(txd_out), .timer2_trigger_pin(trig), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .ext_int2_req(int2));
  ustx_peer ustx_peer_i (.clock(clock), .txd(txd_out), .rxd(peer_rxd));
  // ==========================================================
  // Bench tasks
  task automatic check(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %0h seen %0h", n, e, s);
    end
  endtask : check
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [10:0] a, output logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask : rd
  task automatic wait_hi(input int sel);
    seen = 1'b0;
    for (int k = 0; k < 2000 && !seen; k++) begin
      @(posedge clock);
      seen = (sel == 0) ? tx_irq : (sel == 1) ? rx_irq : int2;
    end
  endtask : wait_hi
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  // ==========================================================
  // Clock and run limit
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    resetn = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 11'h000;
    sfr_wdata = 8'h00;
    trig = 1'b1;
    for (int i = 0; i < 4; i++) b[i] = 8'($random(seed));
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    ustx_peer_i.armed = 1'b1;
    rd(11'h420, rd_v);
    check("ctrl reset", rd_v, 8'h00);
    rd(11'h7FF, rd_v);
    check("unmapped", rd_v, 8'h00);
    // Mode 2 double-buffered send, ninth bit changed mid-stream
    wr(11'h420, 8'h88);
    wr(11'h421, b[0]);
    #1 check("tx idle load", tx_irq, 1'b1);
    wr(11'h420, 8'h88);
    wr(11'h421, b[1]);
    #1 check("tx busy load", tx_irq, 1'b0);
    wait_hi(0);
    check("tx end", seen, 1'b1);
    wr(11'h420, 8'h80);
    wait_hi(0);
    check("tx last", seen, 1'b1);
    check("f0", ustx_peer_i.got_q[0], {2'b11, b[0], 1'b0});
    check("f1", ustx_peer_i.got_q[1], {2'b10, b[1], 1'b0});
    check("gap", ustx_peer_i.start_q[1] - ustx_peer_i.start_q[0], 352);
    ustx_peer_i.got_q.delete();
    // Mode 2 receive with multiprocessor filter
    wr(11'h420, 8'hB0);
    ustx_peer_i.send({2'b10, b[2], 1'b0});
    repeat (40) @(posedge clock);
    #1 check("mp data", rx_irq, 1'b0);
    ustx_peer_i.send({2'b11, b[3], 1'b0});
    wait_hi(1);
    check("mp addr", seen, 1'b1);
    rd(11'h421, rd_v);
    check("rx data", rd_v, b[3]);
    rd(11'h420, rd_v);
    check("rx ninth", rd_v & 8'h05, 8'h05);
    // Receive queue filled until it refuses, then drained
    wr(11'h420, 8'h90);
    for (int i = 0; i < 10; i++) begin
      rq.push_back(8'($random(seed)));
      ustx_peer_i.send({2'b11, rq[i], 1'b0});
    end
    for (int i = 0; i < 9; i++) begin
      rd(11'h421, rd_v);
      check("queue", rd_v, rq[i]);
      wr(11'h420, 8'h90);
      repeat (4) @(posedge clock);
    end
    #1 check("queue full", rx_irq, 1'b0);
    // Mode 1 on timer 1, reload FF, prescale 4: 64 clocks a bit
    wr(11'h434, 8'h00);
    wr(11'h430, 8'hFF);
    wr(11'h420, 8'h70);
    ustx_peer_i.period = 64;
    ustx_peer_i.nbits = 10;
    repeat (1100) @(posedge clock);
    ustx_peer_i.send({2'b10, b[2], 1'b0});
    repeat (80) @(posedge clock);
    #1 check("bad stop", rx_irq, 1'b0);
    rd(11'h422, rd_v);
    check("framing", rd_v[3], 1'b1);
    ustx_peer_i.send({2'b11, b[3], 1'b0});
    wait_hi(1);
    check("m1 rx", seen, 1'b1);
    rd(11'h421, rd_v);
    check("m1 data", rd_v, b[3]);
    wr(11'h421, b[1]);
    wr(11'h420, 8'h70);
    wait_hi(0);
    check("m1 tx", ustx_peer_i.got_q[0], {2'b11, b[1], 1'b0});
    // Timer 2 as source: trigger pin becomes an interrupt input
    wr(11'h418, 8'h10);
    trig <= 1'b0;
    wait_hi(2);
    check("int2", seen, 1'b1);
    // Mode 0: data on the receive line, shift clock on the transmit line
    wr(11'h420, 8'h00);
    wr(11'h421, b[2]);
    #1 check("m0 oe", rxd_oe, 1'b1);
    wr(11'h420, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_out);
      rd_v[i] = rxd_line;
      if (i == 0) t_first = cycles;
      t_last = cycles;
    end
    check("m0 tx", rd_v, b[2]);
    check("m0 rate", t_last - t_first, 112);
    wait_hi(0);
    check("m0 end", seen, 1'b1);
    wr(11'h420, 8'h10);
    ustx_peer_i.shift_in(b[0]);
    wait_hi(1);
    check("m0 rx flag", seen, 1'b1);
    rd(11'h421, rd_v);
    check("m0 rx", rd_v, b[0]);
    test_done();
  end
endmodule : tb
